// [hdl/cascade_irq_params.svh]
`ifndef CASCADE_IRQ_PARAMS_SVH
`define CASCADE_IRQ_PARAMS_SVH
// i/o addresses (low byte of port address)
`define ADDR_MASTER_EVEN 8'h20
`define ADDR_MASTER_ODD 8'h21
`define ADDR_SLAVE_EVEN 8'hA0
`define ADDR_SLAVE_ODD 8'hA1
`define ADDR_IRQ_STATUS 8'hF0
`define ADDR_IRQ_ENABLE 8'hF1
`define ADDR_IRQ_CLEAR 8'hF2
`define ADDR_ACK_CTRL 8'hF3
`define ADDR_ACK_VECTOR 8'hF4
// field positions
`define BIT_INIT_SEL 4
`define BIT_LEVEL_TRIG 3
`define BIT_SINGLE 1
`define BIT_CMD_THREE 3
// cascade line of the master and spurious channel number
`define CASCADE_INPUT 3'h2
`define SPURIOUS_CHANNEL 3'h7
// reset values
`define RST_BYTE 8'h00
`define RST_STATUS 2'h0
`endif

// [hdl/cascade_irq_pkg.sv]
package cascade_irq_pkg;
  typedef enum logic [1:0] {
    INIT_IDLE,
    INIT_WAIT_BASE,
    INIT_WAIT_CASCADE
  } init_state_type;
  typedef logic [7:0] byte_type;
endpackage

// [hdl/cascade_irq_top.sv]
`timescale 1ns/1ps
`include "cascade_irq_params.svh"
// How it works
// - even-address write with bit 4 high is init word one
// - level trigger bit set: high request level raises a request
// - level trigger bit clear: only a rising edge raises a request
// - request dropped before acknowledge yields channel seven vector
// - init word one bit 1 picks single or cascade operation
// - slave interrupt output feeds master request input two
// - slave supplies vector when master's winner is the cascade input
// - vector base word bits 7:3 hold upper vector bits, per controller
// - low three vector bits come from the priority resolver
// - master cascade word marks inputs with slaves attached
// - slave cascade word bits 2:0 hold its identity
// - init word one clears the request mask register
// - even write with bits 4:3 zero is op command two
module cascade_irq_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peripheral requests (master input 2 is the cascade)
  input wire logic [7:0] master_request,
  input wire logic [7:0] slave_request,
  // cpu side
  output logic cpu_int,
  output logic irq
);
  import cascade_irq_pkg::*;
  logic m_int, s_int, m_valid, s_valid, m_single, s_single, m_level, s_level;
  logic [2:0] m_chan, s_chan;
  logic [4:0] m_base, s_base;
  logic [7:0] m_casc, s_casc;
  logic [7:0] m_req;
  logic [7:0] vector_q;
  logic [1:0] status_q, enable_q;
  logic [1:0] cmd_seen_q;
  logic ack_pulse;
  logic use_slave;
  logic [1:0] ev;
  byte_type rd_d;
  ctl_bus_if m_bus ();
  ctl_bus_if s_bus ();

  // -----------------------------------------------------------
  // write decode
  // -----------------------------------------------------------
  assign m_bus.even_wr = reg_wr && reg_addr == `ADDR_MASTER_EVEN;
  assign m_bus.odd_wr = reg_wr && reg_addr == `ADDR_MASTER_ODD;
  assign s_bus.even_wr = reg_wr && reg_addr == `ADDR_SLAVE_EVEN;
  assign s_bus.odd_wr = reg_wr && reg_addr == `ADDR_SLAVE_ODD;
  assign m_bus.wdata = reg_wdata;
  assign s_bus.wdata = reg_wdata;
  assign ack_pulse = reg_wr && reg_addr == `ADDR_ACK_CTRL;
  assign m_bus.ack_take = ack_pulse;
  assign s_bus.ack_take = ack_pulse && use_slave;

  // cascade: slave output replaces master request input two
  always_comb begin
    m_req = master_request;
    if (!m_single) begin
      m_req[`CASCADE_INPUT] = s_int;
    end
  end

  irq_ctl_unit u_master (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(m_bus), .request_input(m_req),
    .int_out(m_int), .top_channel(m_chan), .top_valid(m_valid),
    .base_q(m_base), .cascade_cfg_q(m_casc), .single_q(m_single),
    .level_q(m_level)
  );
  irq_ctl_unit u_slave (
    .clk_sys(clk_sys), .arst_n(arst_n), .bus(s_bus), .request_input(slave_request),
    .int_out(s_int), .top_channel(s_chan), .top_valid(s_valid),
    .base_q(s_base), .cascade_cfg_q(s_casc), .single_q(s_single),
    .level_q(s_level)
  );

  // slave answers when the winner input has a slave and the id matches
  assign use_slave = !m_single && m_valid && m_casc[m_chan]
    && s_casc[2:0] == m_chan;

  // -----------------------------------------------------------
  // acknowledge: vector latched on the acknowledge strobe
  // -----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vector_q <= `RST_BYTE;
    end else if (ack_pulse) begin
      if (use_slave) begin
        vector_q <= {s_base, s_chan};
      end else begin
        vector_q <= {m_base, m_chan};
      end
    end
  end

  // op command two only noted as an event (command three not at all); neither command has any other effect
  always_comb begin
    ev = 2'h0;
    ev[0] = (m_bus.even_wr || s_bus.even_wr) && !reg_wdata[`BIT_INIT_SEL]
      && !reg_wdata[`BIT_CMD_THREE];
    ev[1] = ack_pulse && !m_valid;
  end

  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `RST_STATUS;
    end else begin
      status_q <= (status_q & ~((reg_wr && reg_addr == `ADDR_IRQ_CLEAR)
        ? reg_wdata[1:0] : 2'h0)) | ev;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= `RST_STATUS;
      cmd_seen_q <= `RST_STATUS;
    end else begin
      if (reg_wr && reg_addr == `ADDR_IRQ_ENABLE) begin
        enable_q <= reg_wdata[1:0];
      end
      cmd_seen_q <= {m_level, s_level};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
      cpu_int <= 1'b0;
    end else begin
      irq <= |((status_q | ev) & enable_q);
      cpu_int <= m_int;
    end
  end

  // -----------------------------------------------------------
  // read port
  // -----------------------------------------------------------
  always_comb begin
    case (reg_addr)
      `ADDR_IRQ_STATUS: rd_d = {6'h00, status_q};
      `ADDR_IRQ_ENABLE: rd_d = {6'h00, enable_q};
      `ADDR_ACK_VECTOR: rd_d = vector_q;
      `ADDR_MASTER_EVEN: rd_d = {6'h00, cmd_seen_q};
      default: rd_d = `RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rd_d : `RST_BYTE;
    end
  end

  a_cascade_feed: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !m_single |-> m_req[2] == s_int) else $error("cascade line wrong");
  a_slave_vector: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ack_pulse && use_slave) |=> vector_q == {$past(s_base), $past(s_chan)})
    else $error("slave vector wrong");
  a_master_vector: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ack_pulse && !use_slave) |=> vector_q[2:0] == $past(m_chan))
    else $error("master low bits wrong");
  a_spurious_seven: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ack_pulse && !m_valid) |=> vector_q[2:0] == 3'h7)
    else $error("no spurious seven");
  a_cmd_two: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (m_bus.even_wr && reg_wdata[4:3] == 2'h0) |=> status_q[0])
    else $error("command two not seen");
  a_level_mode: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (m_level && m_req[0] && !u_master.mask_q[0]) |-> m_valid && m_int)
    else $error("level request lost");
endmodule

// [hdl/ctl_bus_if.sv]
`timescale 1ns/1ps
// write port that the top hands to each controller unit
interface ctl_bus_if;
  logic even_wr;
  logic odd_wr;
  logic [7:0] wdata;
  logic ack_take;
  modport top (output even_wr, output odd_wr, output wdata, output ack_take);
  modport unit (input even_wr, input odd_wr, input wdata, input ack_take);
endinterface

// [hdl/irq_ctl_unit.sv]
`timescale 1ns/1ps
`include "cascade_irq_params.svh"
// one priority controller: init-word decode, trigger capture, resolver
module irq_ctl_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // writes from the top
  ctl_bus_if.unit bus,
  // request inputs
  input wire logic [7:0] request_input,
  // state towards the top
  output logic int_out,
  output logic [2:0] top_channel,
  output logic top_valid,
  output logic [4:0] base_q,
  output logic [7:0] cascade_cfg_q,
  output logic single_q,
  output logic level_q
);
  import cascade_irq_pkg::*;
  init_state_type state_q;
  logic [7:0] mask_q;
  logic [7:0] prev_q;
  logic [7:0] pend_q;
  logic [7:0] live;
  logic init_wr;

  function automatic logic [2:0] pick_top(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  assign init_wr = bus.even_wr && bus.wdata[`BIT_INIT_SEL];
  // -----------------------------------------------------------
  // init word sequencing
  // -----------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= INIT_IDLE;
      level_q <= 1'b0;
      single_q <= 1'b0;
      base_q <= 5'h00;
      cascade_cfg_q <= `RST_BYTE;
    end else if (init_wr) begin
      state_q <= INIT_WAIT_BASE;
      level_q <= bus.wdata[`BIT_LEVEL_TRIG];
      single_q <= bus.wdata[`BIT_SINGLE];
    end else if (bus.odd_wr) begin
      case (state_q)
        INIT_WAIT_BASE: begin
          base_q <= bus.wdata[7:3];
          state_q <= single_q ? INIT_IDLE : INIT_WAIT_CASCADE;
        end
        INIT_WAIT_CASCADE: begin
          cascade_cfg_q <= bus.wdata;
          state_q <= INIT_IDLE;
        end
        default: begin
          state_q <= INIT_IDLE;
        end
      endcase
    end
  end

  // mask: cleared by init word one, else written in normal operation
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= `RST_BYTE;
    end else if (init_wr) begin
      mask_q <= `RST_BYTE;
    end else if (bus.odd_wr && state_q == INIT_IDLE) begin
      mask_q <= bus.wdata;
    end
  end

  // edge capture; a level source just stays pending while high
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= `RST_BYTE;
      pend_q <= `RST_BYTE;
    end else begin
      prev_q <= request_input;
      // taking wins over a new edge only for the served channel
      pend_q <= (pend_q | (request_input & ~prev_q)) & request_input;
      if (bus.ack_take && top_valid) begin
        pend_q[top_channel] <= 1'b0;
      end
      if (init_wr) begin
        pend_q <= `RST_BYTE;
      end
    end
  end

  // edge pending must still see the input high, so early drop goes spurious
  assign live = (level_q ? request_input : pend_q) & ~mask_q;
  assign top_valid = |live;
  assign top_channel = top_valid ? pick_top(live) : `SPURIOUS_CHANNEL;
  assign int_out = top_valid;

  a_mask_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    init_wr |=> mask_q == 8'h00) else $error("mask not cleared");
  a_seq_base: assert property (@(posedge clk_sys) disable iff (!arst_n)
    init_wr |=> state_q == INIT_WAIT_BASE) else $error("init seq bad");
  a_base_take: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (bus.odd_wr && !init_wr && state_q == INIT_WAIT_BASE)
    |=> base_q == $past(bus.wdata[7:3])) else $error("base not taken");
endmodule

// [test/cascade_irq_top_tb_top.sv]
`timescale 1ns/1ps
module cascade_irq_top_tb_top;
  logic clk_sys = 1'b0;
  logic arst_n;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] want_m = 8'h00;
  logic [7:0] want_s = 8'h00;
  logic [7:0] master_request;
  logic [7:0] slave_request;
  logic cpu_int;
  logic irq;
  int errors = 0;
  int n_checks = 0;
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  cascade_irq_top u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_request(master_request), .slave_request(slave_request),
    .cpu_int(cpu_int), .irq(irq)
  );
  req_source_model u_src (
    .clk_sys(clk_sys), .arst_n(arst_n), .want_m(want_m), .want_s(want_s),
    .master_request(master_request), .slave_request(slave_request)
  );
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk8($sformatf("read %h", a), exp, d);
  endtask
  // acknowledge, then fetch the vector it latched
  task automatic ack_vec(input logic [7:0] exp);
    wr(`ADDR_ACK_CTRL, 8'h00);
    chk_rd(`ADDR_ACK_VECTOR, exp);
  endtask
  // bounded wait on an interrupt level; 0 selects cpu_int, 1 selects irq
  task automatic wait_lvl(input bit sel, input logic exp);
    int i;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      #1;
      if ((sel ? irq : cpu_int) === exp) break;
    end
    n_checks++;
    if (i == 20) begin
      errors++;
      $display("unexpected %s: expected %b seen %b", sel ? "irq" : "cpu_int", exp,
               sel ? irq : cpu_int);
      end_sim();
    end
  endtask
  task automatic init(input logic [7:0] ev, input logic [7:0] w1, input logic [7:0] base,
                      input logic [7:0] cfg);
    wr(ev, w1);
    wr(ev + 8'h01, base);
    if (!w1[`BIT_SINGLE]) wr(ev + 8'h01, cfg);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    // unknown to low gives the flops a real falling edge at time zero
    arst_n <= 1'b0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    chk_rd(`ADDR_IRQ_STATUS, 8'h00);
    chk_rd(8'h55, 8'h00); // unmapped place reads zero
    wait_lvl(1'b1, 1'b0);
    $display("test reset done");
    // mask everything while idle, then init must unmask it
    wr(`ADDR_MASTER_ODD, 8'hFF);
    init(`ADDR_MASTER_EVEN, 8'h11, 8'h08, 8'h04);
    init(`ADDR_SLAVE_EVEN, 8'h11, 8'h70, 8'h02);
    want_m <= 8'h01;
    wait_lvl(1'b0, 1'b1);
    ack_vec(8'h08);
    wr(`ADDR_IRQ_ENABLE, 8'h02);
    ack_vec(8'h0F);
    wait_lvl(1'b1, 1'b1);
    wr(`ADDR_IRQ_CLEAR, 8'h02);
    wait_lvl(1'b1, 1'b0);
    want_m <= 8'h00;
    $display("test edge master done");
    // slave request goes out through master input two
    want_s <= 8'h08;
    wait_lvl(1'b0, 1'b1);
    ack_vec(8'h73);
    want_s <= 8'h00;
    // early drop before acknowledge
    want_m <= 8'h02;
    repeat (4) @(posedge clk_sys);
    want_m <= 8'h00;
    repeat (4) @(posedge clk_sys);
    ack_vec(8'h0F);
    wr(`ADDR_IRQ_CLEAR, 8'h02);
    $display("test cascade done");
    // level mode: a held line asks again after being served
    init(`ADDR_MASTER_EVEN, 8'h19, 8'h08, 8'h04);
    want_m <= 8'h10;
    wait_lvl(1'b0, 1'b1);
    ack_vec(8'h0C);
    ack_vec(8'h0C);
    want_m <= 8'h00;
    wait_lvl(1'b0, 1'b0);
    $display("test level done");
    // op command two shares the even address but is not an init word
    wr(`ADDR_MASTER_EVEN, 8'h20);
    chk_rd(`ADDR_IRQ_STATUS, 8'h01);
    wr(`ADDR_IRQ_ENABLE, 8'h03);
    wait_lvl(1'b1, 1'b1);
    wr(`ADDR_IRQ_CLEAR, 8'h01);
    wait_lvl(1'b1, 1'b0);
    $display("test command done");
    // single mode: no cascade word, next odd write is the mask
    init(`ADDR_MASTER_EVEN, 8'h13, 8'h08, 8'h00);
    wr(`ADDR_MASTER_ODD, 8'h01);
    want_m <= 8'h01;
    repeat (6) @(posedge clk_sys);
    #1 chk8("cpu_int masked", 8'h00, {7'h00, cpu_int});
    want_m <= 8'h05;
    wait_lvl(1'b0, 1'b1);
    ack_vec(8'h0A);
    want_m <= 8'h00;
    $display("test single done");
    end_sim();
  end
  // no run may hang past this bound
  initial begin
    #100000;
    errors++;
    $display("unexpected timeout: expected end seen none");
    end_sim();
  end
endmodule

// [test/req_source_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// peripheral request sources
// ----------------------------------------
module req_source_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // levels asked for by the bench
  input wire logic [7:0] want_m,
  input wire logic [7:0] want_s,
  // request lines into the device
  output logic [7:0] master_request,
  output logic [7:0] slave_request
);
  // sources change just after an edge, like real peripherals on the same clock;
  // a line is held until the bench says drop, so hold and early drop are both commanded
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      master_request <= 8'h00;
      slave_request <= 8'h00;
    end else begin
      master_request <= want_m;
      slave_request <= want_s;
    end
  end
endmodule
